// file: inc/vdc_pkg.sv
package vdc_pkg;

    // ------------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    localparam logic [ADDR_W-1:0] OFF_DETECT_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_INT_MAIN     = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PERIPH_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PERIPH_ENA   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PERIPH_PRIO  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVT_STATUS   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR    = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_EVT_ENABLE   = 8'h1C;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned BIT_REF_STABLE = 5;
    localparam int unsigned BIT_POWER_EN   = 4;
    localparam int unsigned LEVEL_MSB      = 3;
    localparam int unsigned LEVEL_LSB      = 0;
    localparam int unsigned BIT_GLOBAL_EN  = 7;
    localparam int unsigned BIT_PERIPH_EN  = 6;
    localparam int unsigned BIT_TRIP       = 2;
    localparam int unsigned BE_LOW_LANE    = 0;

    localparam logic [3:0] LEVEL_RESERVED = 4'hF;
    localparam logic [3:0] LEVEL_RESET    = 4'h5;
    localparam logic       POWER_EN_RESET = 1'b0;

    // event status layout
    localparam int unsigned EVT_TRIP = 0;
    localparam int unsigned EVT_WAKE = 1;
    localparam int unsigned EVT_W    = 2;

    localparam logic [EVT_W-1:0]  EVT_NONE  = 2'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } vdc_avm_req_t;

    typedef struct packed {
        logic trip_below;
        logic ref_ready;
    } vdc_ana_in_t;

    typedef struct packed {
        logic       power_en;
        logic [3:0] level;
    } vdc_ana_out_t;

endpackage

// file: logic/vdc_ctrl.sv
// Overview of operation
// R01 - detection keeps running while the core sleeps
// R02 - trip sets flag and wakes sleeping core
// R03 - vector taken only with global enable set
// R04 - any reset returns registers, detector off
// R05 - falling past threshold raises core interrupt request
// R06 - control: stable bit5, enable bit4, level 3:0
// R07 - flag, enable, priority at bit 2
// R08 - main control: global bit7, peripheral bit6 gate
// R09 - unimplemented bits read zero, ignore writes
// R10 - enable bit one powers, zero disables detector
// R11 - level 1111 reserved, 1110 max, 0000 min
// R12 - stable bit one only when reference ready
// R13 - vector needs the individual enable bit too
// R14 - flag stays set until software writes zero
`timescale 1ns/1ps

module vdc_ctrl
(
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire vdc_pkg::vdc_avm_req_t  avm_req,
    output logic [vdc_pkg::DATA_W-1:0]  avm_readdata,
    output logic                        avm_waitrequest,
    input  wire vdc_pkg::vdc_ana_in_t   ana_in,
    output vdc_pkg::vdc_ana_out_t       ana_out,
    input  wire logic                   core_sleep,
    output logic                        wake_req,
    output logic                        vector_high_req,
    output logic                        vector_low_req,
    output logic                        irq
);
    import vdc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic              ref_stable;
    logic              trip_below_q;
    logic              global_high_irq_enable;
    logic              peripheral_low_irq_enable;
    logic              voltage_trip_flag;
    logic              voltage_trip_irq_enable;
    logic              voltage_trip_priority;
    logic [EVT_W-1:0]  evt_status;
    logic [EVT_W-1:0]  evt_enable;

    vdc_ana_out_t      next_ana_out;
    logic              next_ref_stable;
    logic              next_trip_below_q;
    logic              next_global_high_irq_enable;
    logic              next_peripheral_low_irq_enable;
    logic              next_voltage_trip_flag;
    logic              next_voltage_trip_irq_enable;
    logic              next_voltage_trip_priority;
    logic [EVT_W-1:0]  next_evt_status;
    logic [EVT_W-1:0]  next_evt_enable;
    logic              next_wake_req;
    logic              next_vector_high_req;
    logic              next_vector_low_req;
    logic              next_irq;
    logic              next_waitrequest;
    logic [DATA_W-1:0] next_readdata;

    logic              trip_event;
    logic              wr_go;
    logic [REG_W-1:0]  wbyte;
    logic [EVT_W-1:0]  evt_set;
    logic [EVT_W-1:0]  evt_clr;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] off);
        reg_hit = (addr == off);
    endfunction

    // ------------------------------------------------------------------
    // bus slave: one wait cycle, then a one-cycle acknowledge
    // ------------------------------------------------------------------
    assign wbyte = avm_req.writedata[REG_W-1:0];
    assign wr_go = avm_req.write && !avm_waitrequest && avm_req.byteenable[BE_LOW_LANE];

    always_comb
    begin
        next_waitrequest = 1'b1;
        next_readdata    = avm_readdata;
        if ((avm_req.read || avm_req.write) && avm_waitrequest)
        begin
            next_waitrequest = 1'b0;
        end
        if (avm_req.read && avm_waitrequest)
        begin
            next_readdata = DATA_ZERO; // R09
            if (reg_hit(avm_req.address, OFF_DETECT_CTRL))
            begin
                next_readdata[BIT_REF_STABLE]      = ref_stable; // R06
                next_readdata[BIT_POWER_EN]        = ana_out.power_en; // R06
                next_readdata[LEVEL_MSB:LEVEL_LSB] = ana_out.level; // R06
            end
            else if (reg_hit(avm_req.address, OFF_INT_MAIN))
            begin
                next_readdata[BIT_GLOBAL_EN] = global_high_irq_enable; // R08
                next_readdata[BIT_PERIPH_EN] = peripheral_low_irq_enable; // R08
            end
            else if (reg_hit(avm_req.address, OFF_PERIPH_FLAGS))
            begin
                next_readdata[BIT_TRIP] = voltage_trip_flag; // R07
            end
            else if (reg_hit(avm_req.address, OFF_PERIPH_ENA))
            begin
                next_readdata[BIT_TRIP] = voltage_trip_irq_enable; // R07
            end
            else if (reg_hit(avm_req.address, OFF_PERIPH_PRIO))
            begin
                next_readdata[BIT_TRIP] = voltage_trip_priority; // R07
            end
            else if (reg_hit(avm_req.address, OFF_EVT_STATUS))
            begin
                next_readdata[EVT_W-1:0] = evt_status;
            end
            else if (reg_hit(avm_req.address, OFF_EVT_ENABLE))
            begin
                next_readdata[EVT_W-1:0] = evt_enable;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            avm_waitrequest <= 1'b1;
            avm_readdata    <= DATA_ZERO;
        end
        else
        begin
            avm_waitrequest <= next_waitrequest;
            avm_readdata    <= next_readdata;
        end
    end

    // ------------------------------------------------------------------
    // detector control and trip detection
    // ------------------------------------------------------------------
    // comparator is sampled on every clock, independent of core_sleep
    assign trip_event = ana_out.power_en && ana_in.ref_ready
                        && ana_in.trip_below && !trip_below_q; // R01 R05

    always_comb
    begin
        next_ana_out      = ana_out;
        next_ref_stable   = ana_out.power_en && ana_in.ref_ready; // R12
        next_trip_below_q = ana_out.power_en && ana_in.trip_below;
        next_global_high_irq_enable    = global_high_irq_enable;
        next_peripheral_low_irq_enable = peripheral_low_irq_enable;
        next_voltage_trip_irq_enable   = voltage_trip_irq_enable;
        next_voltage_trip_priority     = voltage_trip_priority;
        next_voltage_trip_flag         = voltage_trip_flag;
        if (wr_go && reg_hit(avm_req.address, OFF_DETECT_CTRL))
        begin
            next_ana_out.power_en = wbyte[BIT_POWER_EN]; // R10
            if (wbyte[LEVEL_MSB:LEVEL_LSB] != LEVEL_RESERVED) // R11
            begin
                next_ana_out.level = wbyte[LEVEL_MSB:LEVEL_LSB];
            end
        end
        if (wr_go && reg_hit(avm_req.address, OFF_INT_MAIN))
        begin
            next_global_high_irq_enable    = wbyte[BIT_GLOBAL_EN]; // R08
            next_peripheral_low_irq_enable = wbyte[BIT_PERIPH_EN]; // R08
        end
        if (wr_go && reg_hit(avm_req.address, OFF_PERIPH_ENA))
        begin
            next_voltage_trip_irq_enable = wbyte[BIT_TRIP]; // R07
        end
        if (wr_go && reg_hit(avm_req.address, OFF_PERIPH_PRIO))
        begin
            next_voltage_trip_priority = wbyte[BIT_TRIP]; // R07
        end
        if (wr_go && reg_hit(avm_req.address, OFF_PERIPH_FLAGS))
        begin
            next_voltage_trip_flag = wbyte[BIT_TRIP]; // R14
        end
        if (trip_event)
        begin
            next_voltage_trip_flag = 1'b1; // R02
        end
    end

    // ------------------------------------------------------------------
    // core requests and event interrupt
    // ------------------------------------------------------------------
    assign evt_set = {core_sleep && trip_event, trip_event};
    assign evt_clr = (wr_go && reg_hit(avm_req.address, OFF_EVT_CLEAR))
                     ? wbyte[EVT_W-1:0] : EVT_NONE;

    always_comb
    begin
        next_evt_enable = evt_enable;
        if (wr_go && reg_hit(avm_req.address, OFF_EVT_ENABLE))
        begin
            next_evt_enable = wbyte[EVT_W-1:0];
        end
        // set beats clear in the same cycle
        next_evt_status = (evt_status & ~evt_clr) | evt_set;
        next_irq        = |(next_evt_status & next_evt_enable);
        next_wake_req   = core_sleep && voltage_trip_flag; // R02
        next_vector_high_req = voltage_trip_flag && voltage_trip_irq_enable
                               && voltage_trip_priority
                               && global_high_irq_enable; // R03 R05 R13
        next_vector_low_req  = voltage_trip_flag && voltage_trip_irq_enable
                               && !voltage_trip_priority && global_high_irq_enable
                               && peripheral_low_irq_enable; // R03 R05 R13
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            ana_out.power_en          <= POWER_EN_RESET; // R04
            ana_out.level             <= LEVEL_RESET; // R04
            ref_stable                <= 1'b0;
            trip_below_q              <= 1'b0;
            global_high_irq_enable    <= 1'b0;
            peripheral_low_irq_enable <= 1'b0;
            voltage_trip_flag         <= 1'b0;
            voltage_trip_irq_enable   <= 1'b0;
            voltage_trip_priority     <= 1'b0;
            evt_status                <= EVT_NONE;
            evt_enable                <= EVT_NONE;
            irq                       <= 1'b0;
            wake_req                  <= 1'b0;
            vector_high_req           <= 1'b0;
            vector_low_req            <= 1'b0;
        end
        else
        begin
            ana_out                   <= next_ana_out;
            ref_stable                <= next_ref_stable;
            trip_below_q              <= next_trip_below_q;
            global_high_irq_enable    <= next_global_high_irq_enable;
            peripheral_low_irq_enable <= next_peripheral_low_irq_enable;
            voltage_trip_flag         <= next_voltage_trip_flag;
            voltage_trip_irq_enable   <= next_voltage_trip_irq_enable;
            voltage_trip_priority     <= next_voltage_trip_priority;
            evt_status                <= next_evt_status;
            evt_enable                <= next_evt_enable;
            irq                       <= next_irq;
            wake_req                  <= next_wake_req;
            vector_high_req           <= next_vector_high_req;
            vector_low_req            <= next_vector_low_req;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_trip_sets_flag: assert property ( // R02
        trip_event |=> voltage_trip_flag)
        else $error("trip did not set flag");

    a_flag_is_sticky: assert property ( // R14
        voltage_trip_flag && !(wr_go && reg_hit(avm_req.address, OFF_PERIPH_FLAGS)
        && !wbyte[BIT_TRIP]) |=> voltage_trip_flag)
        else $error("trip flag dropped without software clear");

    a_reset_turns_off: assert property (@(posedge mclk) disable iff (1'b0) // R04
        !reset_n |=> !ana_out.power_en && ana_out.level == LEVEL_RESET && !voltage_trip_flag)
        else $error("reset left detector state");

    a_level_not_reserved: assert property ( // R11
        ana_out.level != LEVEL_RESERVED)
        else $error("reserved level reached detector");

    a_vector_needs_global: assert property ( // R03
        vector_high_req || vector_low_req |-> $past(global_high_irq_enable)
        && $past(voltage_trip_irq_enable) && $past(voltage_trip_flag))
        else $error("vector without enables");

    a_vector_follows_flag: assert property ( // R13
        voltage_trip_flag && voltage_trip_irq_enable && voltage_trip_priority
        && global_high_irq_enable |=> vector_high_req)
        else $error("enabled trip gave no vector");

    a_wake_in_sleep: assert property ( // R02
        core_sleep && trip_event |=> ##1 wake_req || !core_sleep)
        else $error("sleeping core not woken");

    a_ref_off_disabled: assert property ( // R12
        !ana_out.power_en |=> !ref_stable)
        else $error("stable bit set while disabled");

    a_detect_in_sleep: assert property ( // R01
        core_sleep && ana_out.power_en && ana_in.ref_ready && ana_in.trip_below
        && !trip_below_q |=> voltage_trip_flag && evt_status[EVT_WAKE])
        else $error("detection stopped during sleep");

    a_bus_ack_once: assert property (
        (avm_req.read || avm_req.write) && avm_waitrequest |=> !avm_waitrequest ##1 avm_waitrequest)
        else $error("bus acknowledge not one cycle");

    a_unused_read_zero: assert property ( // R09
        avm_req.read && avm_waitrequest && reg_hit(avm_req.address, OFF_DETECT_CTRL)
        |=> avm_readdata[REG_W-1:BIT_REF_STABLE+1] == 2'h0)
        else $error("unimplemented control bits not zero");

    a_enable_write_taken: assert property ( // R10
        wr_go && reg_hit(avm_req.address, OFF_DETECT_CTRL)
        |=> ana_out.power_en == $past(wbyte[BIT_POWER_EN]))
        else $error("enable bit write not taken");

    a_level_write_taken: assert property ( // R11
        wr_go && reg_hit(avm_req.address, OFF_DETECT_CTRL)
        && wbyte[LEVEL_MSB:LEVEL_LSB] != LEVEL_RESERVED
        |=> ana_out.level == $past(wbyte[LEVEL_MSB:LEVEL_LSB]))
        else $error("level write not taken");

    a_reserved_level_kept: assert property ( // R11
        wr_go && reg_hit(avm_req.address, OFF_DETECT_CTRL)
        && wbyte[LEVEL_MSB:LEVEL_LSB] == LEVEL_RESERVED |=> $stable(ana_out.level))
        else $error("reserved level changed setting");

    a_off_no_flag: assert property ( // R10
        !ana_out.power_en && !voltage_trip_flag
        && !(wr_go && reg_hit(avm_req.address, OFF_PERIPH_FLAGS)) |=> !voltage_trip_flag)
        else $error("flag set while detector off");

    a_flag_clear_write: assert property ( // R14
        wr_go && reg_hit(avm_req.address, OFF_PERIPH_FLAGS) && !wbyte[BIT_TRIP]
        && !trip_event |=> !voltage_trip_flag)
        else $error("software clear of flag lost");

    a_stable_needs_ready: assert property ( // R12
        ref_stable |-> $past(ana_out.power_en) && $past(ana_in.ref_ready))
        else $error("stable bit without ready reference");

    a_low_vector_gate: assert property ( // R08
        vector_low_req |-> $past(global_high_irq_enable) && $past(peripheral_low_irq_enable)
        && !$past(voltage_trip_priority))
        else $error("low vector without both enables");

    c_trip_in_sleep: cover property (core_sleep && trip_event ##2 wake_req);
    c_vector_low: cover property (vector_low_req);
    c_set_clear_clash: cover property (trip_event && (evt_clr[EVT_TRIP]));
    c_flag_cleared: cover property (voltage_trip_flag ##1 !voltage_trip_flag);

endmodule

// file: verif/tb.sv
`timescale 1ns/1ps

module tb;
    import vdc_pkg::*;

    logic              mclk;
    logic              reset_n;
    vdc_avm_req_t      req;
    logic [DATA_W-1:0] rdata;
    logic              waitreq;
    vdc_ana_in_t       ana_in;
    vdc_ana_out_t      ana_out;
    logic              core_sleep;
    logic              wake_req;
    logic              vec_hi;
    logic              vec_lo;
    logic              irq;
    logic [4:0]        supply;
    logic [3:0]        be;
    logic [31:0]       q;
    logic [3:0]        lv [3] = '{4'h0, 4'h7, 4'hE};
    int                compares;
    int                miscompares;

    vdc_ctrl i_vdc_ctrl (.mclk(mclk), .reset_n(reset_n), .avm_req(req),
        .avm_readdata(rdata), .avm_waitrequest(waitreq), .ana_in(ana_in),
        .ana_out(ana_out), .core_sleep(core_sleep), .wake_req(wake_req),
        .vector_high_req(vec_hi), .vector_low_req(vec_lo), .irq(irq));

    vdc_analog_model i_vdc_analog_model (.mclk(mclk), .ana_out(ana_out),
        .supply(supply), .ana_in(ana_in));

    // ------------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            miscompares++;
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.read <= ~w;
        req.write <= w;
        req.address <= a;
        req.writedata <= d;
        req.byteenable <= be;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 50);
        if (waitreq !== 1'b0)
        begin
            miscompares++;
            stop_test();
        end
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        for (int i = 0; i < 20; i++)
        begin
            bus(1'b0, a, 32'h0);
            if ((q & m) === exp)
                break;
        end
        chk(q & m, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge mclk);
    endtask

    // ------------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        compares = 0;
        miscompares = 0;
        reset_n = 1'b0;
        req = '0;
        core_sleep = 1'b0;
        supply = 5'h1F;
        be = 4'h1;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd(OFF_DETECT_CTRL, 32'h05);
        rd(OFF_INT_MAIN, 32'h00);
        rd(OFF_PERIPH_FLAGS, 32'h00);
        rd(8'h24, 32'h00);
        be = 4'h2;
        wr(OFF_DETECT_CTRL, 32'h10);
        rd(OFF_DETECT_CTRL, 32'h05);
        be = 4'h1;
        wr(OFF_DETECT_CTRL, 32'hFF);
        chk(32'(ana_out.power_en), 32'h1);
        chk(32'(ana_out.level), 32'h5);
        rd(OFF_DETECT_CTRL, 32'h15);
        poll(OFF_DETECT_CTRL, 32'hFF, 32'h35);
        for (int i = 0; i < 3; i++)
        begin
            wr(OFF_DETECT_CTRL, {28'h1, lv[i]});
            rd(OFF_DETECT_CTRL, {28'h3, lv[i]});
            chk(32'(ana_out.level), 32'(lv[i]));
        end
        wr(OFF_INT_MAIN, 32'hFF);
        rd(OFF_INT_MAIN, 32'hC0);
        wr(OFF_PERIPH_ENA, 32'hFF);
        rd(OFF_PERIPH_ENA, 32'h04);
        wr(OFF_PERIPH_PRIO, 32'hFF);
        rd(OFF_PERIPH_PRIO, 32'h04);
        wr(OFF_EVT_ENABLE, 32'h03);
        supply <= 5'h0E;
        poll(OFF_PERIPH_FLAGS, 32'hFF, 32'h04);
        settle();
        chk(32'({vec_hi, vec_lo, irq, wake_req}), 32'hA);
        rd(OFF_EVT_STATUS, 32'h01);
        supply <= 5'h1F;
        settle();
        rd(OFF_PERIPH_FLAGS, 32'h04);
        wr(OFF_INT_MAIN, 32'h40);
        settle();
        chk(32'(vec_hi), 32'h0);
        wr(OFF_PERIPH_PRIO, 32'h00);
        wr(OFF_INT_MAIN, 32'hC0);
        settle();
        chk(32'(vec_lo), 32'h1);
        wr(OFF_INT_MAIN, 32'h80);
        settle();
        chk(32'(vec_lo), 32'h0);
        wr(OFF_INT_MAIN, 32'hC0);
        wr(OFF_PERIPH_ENA, 32'h00);
        settle();
        chk(32'(vec_lo), 32'h0);
        wr(OFF_PERIPH_FLAGS, 32'h00);
        rd(OFF_PERIPH_FLAGS, 32'h00);
        wr(OFF_EVT_CLEAR, 32'h01);
        rd(OFF_EVT_STATUS, 32'h00);
        chk(32'(irq), 32'h0);
        core_sleep <= 1'b1;
        supply <= 5'h0E;
        poll(OFF_PERIPH_FLAGS, 32'hFF, 32'h04);
        settle();
        chk(32'(wake_req), 32'h1);
        rd(OFF_EVT_STATUS, 32'h03);
        wr(OFF_EVT_ENABLE, 32'h00);
        settle();
        chk(32'(irq), 32'h0);
        wr(OFF_EVT_ENABLE, 32'h02);
        settle();
        chk(32'(irq), 32'h1);
        wr(OFF_EVT_CLEAR, 32'h03);
        settle();
        chk(32'(irq), 32'h0);
        wr(OFF_DETECT_CTRL, 32'h0E);
        settle();
        chk(32'(ana_out.power_en), 32'h0);
        rd(OFF_DETECT_CTRL, 32'h0E);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd(OFF_DETECT_CTRL, 32'h05);
        rd(OFF_PERIPH_FLAGS, 32'h00);
        chk(32'({ana_out.power_en, wake_req, irq}), 32'h0);
        stop_test();
    end
endmodule

// file: verif/vdc_analog_model.sv
`timescale 1ns/1ps

module vdc_analog_model
#(
    parameter int REF_DELAY = 8
)
(
    input  wire logic                   mclk,
    input  wire vdc_pkg::vdc_ana_out_t  ana_out,
    input  wire logic [4:0]             supply,
    output vdc_pkg::vdc_ana_in_t        ana_in
);
    import vdc_pkg::*;

    // ------------------------------------------------------------------
    // reference settling and comparator
    // ------------------------------------------------------------------
    int unsigned settle_cnt = 0;
    logic        toggle     = 1'b0;

    // unpowered comparator output is meaningless: keep it moving
    always @(posedge mclk)
    begin
        toggle <= ~toggle;
        if (!ana_out.power_en)
            settle_cnt <= 0;
        else if (settle_cnt < REF_DELAY)
            settle_cnt <= settle_cnt + 1;
    end

    always_comb
    begin
        ana_in.ref_ready  = ana_out.power_en && (settle_cnt == REF_DELAY);
        ana_in.trip_below = ana_out.power_en ? (supply <= {1'b0, ana_out.level}) : toggle;
    end
endmodule
